/* File: hw/radio_ctrl_pkg.sv */
package radio_ctrl_pkg;
    // register bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [4:0] OFF_STROBE = 5'h00;
    localparam logic [4:0] OFF_CFG_A = 5'h01;
    localparam logic [4:0] OFF_CFG_B = 5'h02;
    localparam logic [4:0] OFF_CFG_C = 5'h03;
    localparam logic [4:0] OFF_BASE_HI = 5'h04;
    localparam logic [4:0] OFF_BASE_MID = 5'h05;
    localparam logic [4:0] OFF_BASE_LO = 5'h06;
    localparam logic [4:0] OFF_SLOT = 5'h07;
    localparam logic [4:0] OFF_MODEM_LOW = 5'h08;
    localparam logic [4:0] OFF_MODEM_HIGH = 5'h09;
    localparam logic [4:0] OFF_SYNTH_CTRL = 5'h0A;
    localparam logic [4:0] OFF_STATE = 5'h0B;
    localparam logic [4:0] OFF_WORD_HI = 5'h0C;
    localparam logic [4:0] OFF_WORD_MID = 5'h0D;
    localparam logic [4:0] OFF_WORD_LO = 5'h0E;

    // command codes written to the strobe register
    localparam logic [7:0] CMD_CALIBRATE = 8'h01;
    localparam logic [7:0] CMD_RECEIVE = 8'h02;
    localparam logic [7:0] CMD_TRANSMIT = 8'h03;
    localparam logic [7:0] CMD_SYNTH_TX = 8'h04;
    localparam logic [7:0] CMD_GO_IDLE = 8'h05;

    // field positions
    localparam int CFGB_CCA_LSB = 4;
    localparam int CFGB_AFTER_RX_LSB = 2;
    localparam int CFGB_AFTER_TX_LSB = 0;
    localparam int CFGC_CARRIER_BIT = 4;
    localparam int CFGC_QUAL_BIT = 3;
    localparam int CFGC_TIMEOUT_LSB = 0;

    // reset values
    localparam logic [7:0] CFG_A_RESET = 8'h00;
    localparam logic [7:0] CFG_B_RESET = 8'h00;
    localparam logic [7:0] CFG_C_RESET = 8'h07;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // automatic calibration choices
    localparam logic [1:0] AUTOCAL_NEVER = 2'h0;
    localparam logic [1:0] AUTOCAL_ON_START = 2'h1;
    localparam logic [1:0] AUTOCAL_ON_IDLE = 2'h2;
    localparam logic [1:0] AUTOCAL_FOURTH = 2'h3;

    // post-packet destinations
    localparam logic [1:0] DEST_IDLE = 2'h0;
    localparam logic [1:0] DEST_SYNTH_TX = 2'h1;
    localparam logic [1:0] DEST_TX = 2'h2;
    localparam logic [1:0] DEST_RX = 2'h3;

    // transition timing in crystal periods (one sys_clk per period)
    localparam int CAL_PERIODS = 18739;
    localparam int SETTLE_PERIODS = 2298;
    localparam int TX_TO_RX_PERIODS = 560;
    localparam int RX_TO_TX_PERIODS = 250;
    localparam int TO_IDLE_PERIODS = 2;
    localparam logic [14:0] SETTLE_LOAD = 15'(SETTLE_PERIODS - 1);
    localparam logic [14:0] TX_TO_RX_LOAD = 15'(TX_TO_RX_PERIODS - 1);
    localparam logic [14:0] RX_TO_TX_LOAD = 15'(RX_TO_TX_PERIODS - 1);
    localparam logic [14:0] TO_IDLE_LOAD = 15'(TO_IDLE_PERIODS - 1);

    // receive timeout: base count shifted by setting, top setting disables
    localparam logic [14:0] TIMEOUT_BASE = 15'h0100;
    localparam logic [2:0] TIMEOUT_OFF = 3'h7;
    localparam logic [3:0] OOK_SYMBOLS = 4'h8;
    localparam logic [8:0] SPACING_OFFSET = 9'h100;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_CAL = 4'h1,
        ST_SETTLE = 4'h3,
        ST_RX = 4'h2,
        ST_TX = 4'h6,
        ST_SYNTH_TX = 4'h7,
        ST_RX_TO_TX = 4'h5,
        ST_TX_TO_RX = 4'h4,
        ST_ENDING = 4'hC
    } radio_state_t;
endpackage : radio_ctrl_pkg

/* File: hw/radio_state_controller.sv */
`timescale 1ns/1ps
module radio_state_controller
#(
    parameter int CAL_CYCLES = radio_ctrl_pkg::CAL_PERIODS
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire logic [radio_ctrl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [radio_ctrl_pkg::DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [radio_ctrl_pkg::DATA_W-1:0] regReadData,
    // receive and transmit path flags
    input wire logic packetReceived,
    input wire logic packetSent,
    input wire logic syncFound,
    input wire logic preambleQualityReached,
    input wire logic carrierSense,
    input wire logic carrierSampleValid,
    input wire logic rssiBelowThreshold,
    input wire logic receivingPacket,
    input wire logic ookMode,
    input wire logic symbolTick,
    // radio front end control
    output logic rxEnable,
    output logic txEnable,
    output logic synthEnable,
    output logic calibrating,
    output logic [23:0] synthWord,
    output logic [4:0] intermediateOffsetWord
);
    import radio_ctrl_pkg::*;

    localparam logic [14:0] CAL_LOAD = 15'(CAL_CYCLES - 1);

    radio_state_t state;
    radio_state_t next_state;
    radio_state_t target;
    radio_state_t next_target;
    logic [14:0] waitCount;
    logic [14:0] next_wait;
    logic [7:0] cfgA;
    logic [7:0] cfgB;
    logic [7:0] cfgC;
    logic [7:0] baseHi;
    logic [7:0] baseMid;
    logic [7:0] baseLo;
    logic [7:0] slotNumber;
    logic [7:0] spacingMantissa;
    logic [1:0] spacingExponent;
    logic [4:0] offsetWord;
    logic [1:0] idleReturns;
    logic endWithCal;
    logic restartRx;
    logic demodRestart;
    logic [14:0] rxTimer;
    logic [3:0] symbolCount;
    logic carrierChecked;

    // strobe decode: one command per write
    logic strobeWrite;
    logic calStrobe;
    logic rxStrobe;
    logic txStrobe;
    logic synthStrobe;
    logic idleStrobe;
    assign strobeWrite = regWrite && (regAddr == OFF_STROBE);
    assign calStrobe = strobeWrite && (regWriteData == CMD_CALIBRATE);
    assign rxStrobe = strobeWrite && (regWriteData == CMD_RECEIVE);
    assign txStrobe = strobeWrite && (regWriteData == CMD_TRANSMIT);
    assign synthStrobe = strobeWrite && (regWriteData == CMD_SYNTH_TX);
    assign idleStrobe = strobeWrite && (regWriteData == CMD_GO_IDLE);

    // configuration fields
    logic [1:0] autocalSelect;
    logic [1:0] ccaSelect;
    logic [1:0] afterRx;
    logic [1:0] afterTx;
    logic carrierTerminateOn;
    logic timeoutQualifier;
    logic [2:0] rxTimeout;
    assign autocalSelect = cfgA[1:0];
    assign ccaSelect = cfgB[CFGB_CCA_LSB +: 2];
    assign afterRx = cfgB[CFGB_AFTER_RX_LSB +: 2];
    assign afterTx = cfgB[CFGB_AFTER_TX_LSB +: 2];
    assign carrierTerminateOn = cfgC[CFGC_CARRIER_BIT];
    assign timeoutQualifier = cfgC[CFGC_QUAL_BIT];
    assign rxTimeout = cfgC[CFGC_TIMEOUT_LSB +: 3];

    // clear channel decision
    logic channelClear;
    always_comb
    begin
        case (ccaSelect)
            2'h0: channelClear = 1'b1;
            2'h1: channelClear = rssiBelowThreshold;
            2'h2: channelClear = !receivingPacket;
            default: channelClear = rssiBelowThreshold && !receivingPacket;
        endcase
    end

    // termination: timer expiry unless a stay condition holds, or no carrier at the first valid carrier sample
    logic timeoutEnabled;
    logic timerExpired;
    logic stayInRx;
    logic timeoutEnd;
    logic carrierValidNow;
    logic carrierEnd;
    assign timeoutEnabled = (rxTimeout != TIMEOUT_OFF);
    assign timerExpired = timeoutEnabled && (rxTimer >= (TIMEOUT_BASE << rxTimeout));
    assign stayInRx = syncFound || (timeoutQualifier && preambleQualityReached);
    assign timeoutEnd = (state == ST_RX) && timerExpired && !stayInRx;
    assign carrierValidNow = carrierSampleValid && (!ookMode || symbolCount == OOK_SYMBOLS);
    assign carrierEnd = (state == ST_RX) && carrierTerminateOn && !carrierChecked
        && carrierValidNow && !carrierSense;

    // calibration on return to idle: always, or on every fourth return
    logic returnCal;
    logic [14:0] endLoad;
    assign returnCal = (autocalSelect == AUTOCAL_ON_IDLE)
        || (autocalSelect == AUTOCAL_FOURTH && idleReturns == 2'h3);
    assign endLoad = returnCal ? CAL_LOAD : TO_IDLE_LOAD;

    // next state; go-idle is applied last so it wins over everything
    always_comb
    begin
        next_state = state;
        next_target = target;
        next_wait = (waitCount != 15'h0000) ? waitCount - 15'h0001 : waitCount;
        restartRx = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (rxStrobe || txStrobe || synthStrobe)
                begin
                    next_target = rxStrobe ? ST_RX : (txStrobe ? ST_TX : ST_SYNTH_TX);
                    if (autocalSelect == AUTOCAL_ON_START)
                    begin
                        next_state = ST_CAL;
                        next_wait = CAL_LOAD;
                    end
                    else
                    begin
                        next_state = ST_SETTLE;
                        next_wait = SETTLE_LOAD;
                    end
                end
                else if (calStrobe)
                begin
                    next_state = ST_CAL;
                    next_target = ST_IDLE;
                    next_wait = CAL_LOAD;
                end
            end
            ST_CAL:
            begin
                if (waitCount == 15'h0000)
                begin
                    next_state = (target == ST_IDLE) ? ST_IDLE : ST_SETTLE;
                    next_wait = SETTLE_LOAD;
                end
            end
            ST_SETTLE, ST_RX_TO_TX, ST_TX_TO_RX:
            begin
                if (waitCount == 15'h0000)
                begin
                    next_state = target;
                end
            end
            ST_RX:
            begin
                if ((txStrobe || synthStrobe) && channelClear)
                begin
                    next_state = ST_RX_TO_TX;
                    next_target = txStrobe ? ST_TX : ST_SYNTH_TX;
                    next_wait = RX_TO_TX_LOAD;
                end
                else if (timeoutEnd || carrierEnd)
                begin
                    next_state = ST_ENDING;
                    next_wait = endLoad;
                end
                else if (packetReceived)
                begin
                    case (afterRx)
                        DEST_IDLE:
                        begin
                            next_state = ST_ENDING;
                            next_wait = endLoad;
                        end
                        DEST_SYNTH_TX, DEST_TX:
                        begin
                            next_state = ST_RX_TO_TX;
                            next_target = (afterRx == DEST_TX) ? ST_TX : ST_SYNTH_TX;
                            next_wait = RX_TO_TX_LOAD;
                        end
                        default: restartRx = 1'b1;
                    endcase
                end
            end
            ST_TX:
            begin
                if (rxStrobe)
                begin
                    next_state = ST_TX_TO_RX;
                    next_target = ST_RX;
                    next_wait = TX_TO_RX_LOAD;
                end
                else if (packetSent)
                begin
                    case (afterTx)
                        DEST_IDLE:
                        begin
                            next_state = ST_ENDING;
                            next_wait = endLoad;
                        end
                        DEST_SYNTH_TX: next_state = ST_SYNTH_TX;
                        DEST_TX: next_state = ST_TX;
                        default:
                        begin
                            next_state = ST_TX_TO_RX;
                            next_target = ST_RX;
                            next_wait = TX_TO_RX_LOAD;
                        end
                    endcase
                end
            end
            ST_SYNTH_TX:
            begin
                if (txStrobe)
                begin
                    next_state = ST_TX;
                end
                else if (rxStrobe)
                begin
                    next_state = ST_TX_TO_RX;
                    next_target = ST_RX;
                    next_wait = TX_TO_RX_LOAD;
                end
            end
            ST_ENDING:
            begin
                if (waitCount == 15'h0000)
                begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (idleStrobe && state != ST_IDLE && state != ST_ENDING)
        begin
            next_state = ST_ENDING;
            next_wait = endLoad;
        end
    end

    // state, target and transition counter
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            target <= ST_IDLE;
            waitCount <= 15'h0000;
        end
        else
        begin
            state <= next_state;
            target <= next_target;
            waitCount <= next_wait;
        end
    end

    // count returns to idle for the every-fourth calibration choice
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            idleReturns <= 2'h0;
            endWithCal <= 1'b0;
        end
        else if (next_state == ST_ENDING && state != ST_ENDING)
        begin
            idleReturns <= idleReturns + 2'h1;
            endWithCal <= returnCal;
        end
    end

    // termination timer restarts whenever the demodulator is (re)enabled
    assign demodRestart = (next_state == ST_RX) && (state != ST_RX || restartRx);
    always_ff @(posedge sys_clk)
    begin
        if (reset || demodRestart)
        begin
            rxTimer <= 15'h0000;
            symbolCount <= 4'h0;
            carrierChecked <= 1'b0;
        end
        else if (state == ST_RX)
        begin
            if (!timerExpired)
            begin
                rxTimer <= rxTimer + 15'h0001;
            end
            if (symbolTick && symbolCount != OOK_SYMBOLS)
            begin
                symbolCount <= symbolCount + 4'h1;
            end
            // only the first valid sample counts; later gaps are not fatal
            if (carrierValidNow)
            begin
                carrierChecked <= 1'b1;
            end
        end
    end

    // software registers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cfgA <= CFG_A_RESET;
            cfgB <= CFG_B_RESET;
            cfgC <= CFG_C_RESET;
            baseHi <= BYTE_RESET;
            baseMid <= BYTE_RESET;
            baseLo <= BYTE_RESET;
            slotNumber <= BYTE_RESET;
            spacingMantissa <= BYTE_RESET;
            spacingExponent <= 2'h0;
            offsetWord <= 5'h00;
        end
        else if (regWrite)
        begin
            case (regAddr)
                OFF_CFG_A: cfgA <= regWriteData;
                OFF_CFG_B: cfgB <= regWriteData;
                OFF_CFG_C: cfgC <= regWriteData;
                OFF_BASE_HI: baseHi <= regWriteData;
                OFF_BASE_MID: baseMid <= regWriteData;
                OFF_BASE_LO: baseLo <= regWriteData;
                OFF_SLOT: slotNumber <= regWriteData;
                OFF_MODEM_LOW: spacingMantissa <= regWriteData;
                OFF_MODEM_HIGH: spacingExponent <= regWriteData[1:0];
                OFF_SYNTH_CTRL: offsetWord <= regWriteData[4:0];
                default: ;
            endcase
        end
    end

    // synth word; no guard against writes while running, software keeps to idle
    logic [11:0] spacingScaled;
    logic [19:0] slotProduct;
    assign spacingScaled = 12'({SPACING_OFFSET[8:0] + {1'b0, spacingMantissa}} << spacingExponent);
    assign slotProduct = slotNumber * spacingScaled;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            synthWord <= 24'h000000;
            intermediateOffsetWord <= 5'h00;
        end
        else
        begin
            synthWord <= {baseHi, baseMid, baseLo} + {6'h00, slotProduct[19:2]};
            intermediateOffsetWord <= offsetWord;
        end
    end

    // read port: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            regReadData <= 8'h00;
        end
        else if (regRead)
        begin
            case (regAddr)
                OFF_CFG_A: regReadData <= cfgA;
                OFF_CFG_B: regReadData <= cfgB;
                OFF_CFG_C: regReadData <= cfgC;
                OFF_BASE_HI: regReadData <= baseHi;
                OFF_BASE_MID: regReadData <= baseMid;
                OFF_BASE_LO: regReadData <= baseLo;
                OFF_SLOT: regReadData <= slotNumber;
                OFF_MODEM_LOW: regReadData <= spacingMantissa;
                OFF_MODEM_HIGH: regReadData <= {6'h00, spacingExponent};
                OFF_SYNTH_CTRL: regReadData <= {3'h0, offsetWord};
                OFF_STATE: regReadData <= {4'h0, state};
                OFF_WORD_HI: regReadData <= synthWord[23:16];
                OFF_WORD_MID: regReadData <= synthWord[15:8];
                OFF_WORD_LO: regReadData <= synthWord[7:0];
                default: regReadData <= 8'h00;
            endcase
        end
        else
        begin
            regReadData <= 8'h00;
        end
    end

    // front end enables decoded from the state flop; calibrating also uses endWithCal
    assign rxEnable = (state == ST_RX);
    assign txEnable = (state == ST_TX);
    assign synthEnable = (state != ST_IDLE) && (state != ST_CAL) && (state != ST_ENDING);
    assign calibrating = (state == ST_CAL) || (state == ST_ENDING && endWithCal);

    // checks
    sequence shortReturn;
        state == ST_ENDING [*2] ##1 state == ST_IDLE;
    endsequence

    sequence turnToRx;
        state == ST_TX_TO_RX && waitCount == TX_TO_RX_LOAD;
    endsequence

    chk_idle_strobe_forces: assert property (@(posedge sys_clk) disable iff (reset)
        idleStrobe |=> state inside {ST_IDLE, ST_ENDING})
        else $error("go-idle strobe did not force idle");

    chk_quick_return_idle: assert property (@(posedge sys_clk) disable iff (reset)
        (state == ST_RX && idleStrobe && autocalSelect == AUTOCAL_NEVER) |=> shortReturn)
        else $error("return to idle did not take two cycles");

    chk_start_settle_time: assert property (@(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && rxStrobe && autocalSelect == AUTOCAL_NEVER)
        |=> state == ST_SETTLE && waitCount == SETTLE_LOAD)
        else $error("idle to receive settle count wrong");

    chk_cal_length_load: assert property (@(posedge sys_clk) disable iff (reset)
        (state != ST_CAL && next_state == ST_CAL) |=> waitCount == CAL_LOAD)
        else $error("calibration length wrong");

    chk_tx_abort_rx: assert property (@(posedge sys_clk) disable iff (reset)
        (state == ST_TX && rxStrobe) |=> turnToRx)
        else $error("receive strobe did not abort transmit");

    chk_cca_blocks_tx: assert property (@(posedge sys_clk) disable iff (reset)
        (state == ST_RX && txStrobe && !channelClear && !timeoutEnd && !carrierEnd
        && !packetReceived) |=> state == ST_RX)
        else $error("transmit strobe left receive on busy channel");

    chk_rx_to_tx_turn: assert property (@(posedge sys_clk) disable iff (reset)
        (state == ST_RX_TO_TX && $past(state) == ST_RX) |-> waitCount == RX_TO_TX_LOAD)
        else $error("receive to transmit turnaround count wrong");

    chk_carrier_end_idle: assert property (@(posedge sys_clk) disable iff (reset)
        (carrierEnd && !txStrobe && !synthStrobe) |=> state == ST_ENDING)
        else $error("carrier termination did not head to idle");

    chk_sent_to_rx: assert property (@(posedge sys_clk) disable iff (reset)
        (state == ST_TX && packetSent && !strobeWrite && afterTx == DEST_RX) |=> turnToRx)
        else $error("after-transmit receive destination not taken");

    chk_start_needs_strobe: assert property (@(posedge sys_clk) disable iff (reset)
        (state == ST_IDLE && next_state == ST_SETTLE) |-> (rxStrobe || txStrobe || synthStrobe))
        else $error("radio started without a strobe");
endmodule : radio_state_controller

/* File: tb/cpu_model.sv */
`timescale 1ns/1ps
// cpu side of the register port: one-cycle strobes, never both at once
module cpu_model
(
    // clock
    input wire logic sys_clk,
    // register port
    output logic [4:0] regAddr,
    output logic [7:0] regWriteData,
    output logic regWrite,
    output logic regRead,
    input wire logic [7:0] regReadData
);
    initial {regAddr, regWriteData, regWrite, regRead} = '0;
    // frequency words are written only from idle; the strobe register is also written in receive and transmit
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regReadData;
    endtask : rd
endmodule : cpu_model

/* File: tb/radio_state_controller_tb_top.sv */
`timescale 1ns/1ps
module radio_state_controller_tb_top;
    import radio_ctrl_pkg::*;
    logic sys_clk = 0, reset = 1, pRx = 0, pTx = 0, rxOn, txOn, syn, cal;
    logic syncHit = 0, pqr = 0, cs = 0, csv = 0, rssiLow = 0, rcvPkt = 0, ook = 0, tick = 0;
    localparam int CAL_SIM = 20;
    logic [4:0] addr, ifw;
    logic [7:0] wd, rdat, v;
    logic we, re;
    logic [23:0] sw;
    int fail_count = 0, total_checks = 0, cyc = 0, n;
    // clock and cycle ceiling; a hang counts as a mismatch
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cyc > 40000) begin fail_count++; give_verdict(); end
    cpu_model cpu (.sys_clk(sys_clk), .regAddr(addr), .regWriteData(wd), .regWrite(we),
        .regRead(re), .regReadData(rdat));
    // estimator flags are levels set by the scenarios; a short calibration keeps runs brief
    radio_state_controller #(.CAL_CYCLES(CAL_SIM)) dut (.sys_clk(sys_clk), .reset(reset),
        .regAddr(addr), .regWriteData(wd), .regWrite(we), .regRead(re), .regReadData(rdat),
        .packetReceived(pRx), .packetSent(pTx), .syncFound(syncHit),
        .preambleQualityReached(pqr), .carrierSense(cs), .carrierSampleValid(csv),
        .rssiBelowThreshold(rssiLow), .receivingPacket(rcvPkt), .ookMode(ook),
        .symbolTick(tick), .rxEnable(rxOn), .txEnable(txOn), .synthEnable(syn),
        .calibrating(cal), .synthWord(sw), .intermediateOffsetWord(ifw));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // edges counted from the strobe until the enable shows
    task wait_on(input logic tx);
        n = 0;
        do begin @(posedge sys_clk); #1 n++; end while ((tx ? txOn : rxOn) !== 1 && n < 3000);
    endtask : wait_on
    task t_base_carrier_word;
        cpu.wr(OFF_BASE_HI, 8'h12);
        cpu.wr(OFF_BASE_MID, 8'h34);
        cpu.wr(OFF_BASE_LO, 8'h56);
        cpu.wr(OFF_SLOT, 8'h03);
        cpu.wr(OFF_MODEM_LOW, 8'h10);
        cpu.wr(OFF_MODEM_HIGH, 8'h02);
        cpu.wr(OFF_SYNTH_CTRL, 8'h15);
        repeat (3) @(posedge sys_clk);
        chk(sw, 32'h123786);
        chk(ifw, 5'h15);
    endtask : t_base_carrier_word
    task t_rx_tx_idle;
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        chk(n, SETTLE_PERIODS);
        cpu.wr(OFF_STROBE, CMD_TRANSMIT);
        wait_on(1);
        chk(n, RX_TO_TX_PERIODS);
        @(posedge sys_clk) pTx <= 1;
        @(posedge sys_clk) pTx <= 0;
        repeat (4) @(posedge sys_clk);
        cpu.rd(OFF_STATE, v);
        chk(v, 8'h00);
    endtask : t_rx_tx_idle
    // qualifier 0 ignores preamble quality; qualifier 1 keeps receive while either flag stands
    task t_timeout;
        cpu.wr(OFF_CFG_C, 8'h00);
        cpu.wr(OFF_CFG_B, 8'h0C);
        @(posedge sys_clk) pqr <= 1;
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        repeat (250) @(posedge sys_clk);
        #1 chk(rxOn, 1'b1);
        repeat (50) @(posedge sys_clk);
        #1 chk(rxOn, 1'b0);
        cpu.rd(OFF_STATE, v);
        chk(v, 8'h00);
        cpu.wr(OFF_CFG_C, 8'h08);
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        repeat (300) @(posedge sys_clk);
        #1 chk(rxOn, 1'b1);
        @(posedge sys_clk) {pqr, syncHit} <= 2'b01;
        repeat (50) @(posedge sys_clk);
        #1 chk(rxOn, 1'b1);
        @(posedge sys_clk) syncHit <= 0;
        repeat (5) @(posedge sys_clk);
        cpu.rd(OFF_STATE, v);
        chk(v, 8'h00);
    endtask : t_timeout
    task t_go_idle;
        cpu.wr(OFF_CFG_C, 8'h07);
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        chk(syn, 1'b1);
        cpu.wr(OFF_STROBE, CMD_GO_IDLE);
        repeat (4) @(posedge sys_clk);
        cpu.rd(OFF_STATE, v);
        chk(v, 8'h00);
        chk(syn, 1'b0);
    endtask : t_go_idle
    // busy channel drops the transmit strobe; a second strobe after the packet flag drops starts transmit
    task t_cca;
        cpu.wr(OFF_CFG_B, 8'h30);
        @(posedge sys_clk) {rssiLow, rcvPkt} <= 2'b11;
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        cpu.wr(OFF_STROBE, CMD_TRANSMIT);
        repeat (300) @(posedge sys_clk);
        #1 chk(rxOn, 1'b1);
        @(posedge sys_clk) rcvPkt <= 0;
        cpu.wr(OFF_STROBE, CMD_TRANSMIT);
        wait_on(1);
        chk(n, RX_TO_TX_PERIODS);
        cpu.wr(OFF_STROBE, CMD_GO_IDLE);
        repeat (4) @(posedge sys_clk);
    endtask : t_cca
    // after-receive to transmit, abort back to receive, after-transmit to receive
    task t_turn;
        cpu.wr(OFF_CFG_B, 8'h0B);
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        @(posedge sys_clk) pRx <= 1;
        @(posedge sys_clk) pRx <= 0;
        wait_on(1);
        chk(n, RX_TO_TX_PERIODS);
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        chk(n, TX_TO_RX_PERIODS);
        cpu.wr(OFF_STROBE, CMD_TRANSMIT);
        wait_on(1);
        @(posedge sys_clk) pTx <= 1;
        @(posedge sys_clk) pTx <= 0;
        wait_on(0);
        chk(n, TX_TO_RX_PERIODS);
        cpu.wr(OFF_STROBE, CMD_GO_IDLE);
        repeat (4) @(posedge sys_clk);
    endtask : t_turn
    // only the first valid carrier sample decides; keyed mode waits eight symbols
    task t_carrier;
        cpu.wr(OFF_CFG_C, 8'h17);
        @(posedge sys_clk) cs <= 1;
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        @(posedge sys_clk) csv <= 1;
        @(posedge sys_clk) cs <= 0;
        repeat (20) @(posedge sys_clk);
        #1 chk(rxOn, 1'b1);
        cpu.wr(OFF_STROBE, CMD_GO_IDLE);
        // strobes are ignored while the return to idle runs
        repeat (2) @(posedge sys_clk);
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        chk(n, SETTLE_PERIODS);
        @(posedge sys_clk);
        #1 chk(rxOn, 1'b0);
        repeat (4) @(posedge sys_clk);
        @(posedge sys_clk) ook <= 1;
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        repeat (20) @(posedge sys_clk);
        #1 chk(rxOn, 1'b1);
        repeat (8)
        begin
            @(posedge sys_clk) tick <= 1;
            @(posedge sys_clk) tick <= 0;
        end
        repeat (4) @(posedge sys_clk);
        cpu.rd(OFF_STATE, v);
        chk(v, 8'h00);
        @(posedge sys_clk) {ook, csv} <= 2'b00;
    endtask : t_carrier
    // calibration flag stands exactly CAL_SIM cycles from the edge that took the strobe
    task cal_span;
        #1 chk(cal, 1'b1);
        repeat (CAL_SIM - 1) @(posedge sys_clk);
        #1 chk(cal, 1'b1);
        @(posedge sys_clk);
        #1 chk(cal, 1'b0);
    endtask : cal_span
    // calibrate on start, on return to idle, and by the manual strobe
    task t_cal;
        cpu.wr(OFF_CFG_A, {6'h00, AUTOCAL_ON_START});
        cpu.wr(OFF_STROBE, CMD_RECEIVE);
        wait_on(0);
        chk(n, CAL_SIM + SETTLE_PERIODS);
        cpu.wr(OFF_CFG_A, {6'h00, AUTOCAL_ON_IDLE});
        cpu.wr(OFF_STROBE, CMD_GO_IDLE);
        cal_span();
        cpu.wr(OFF_CFG_A, 8'h00);
        cpu.wr(OFF_STROBE, CMD_CALIBRATE);
        cal_span();
    endtask : t_cal
    task give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // main sequence
    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 0;
        cpu.rd(OFF_STATE, v);
        chk(v, 8'h00);
        t_base_carrier_word();
        t_rx_tx_idle();
        t_timeout();
        t_go_idle();
        t_cca();
        t_turn();
        t_carrier();
        t_cal();
        give_verdict();
    end
endmodule : radio_state_controller_tb_top
